// file: design/aic_pkg.sv
// constants, register map and helpers shared by both ends of the control link
package aic_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // register map
  localparam logic [6:0] ADDR_IF_CTRL = 7'h0E;
  localparam logic [6:0] ADDR_IDENT   = 7'h0F;
  localparam logic [6:0] ADDR_CTRL1   = 7'h10;
  localparam logic [6:0] ADDR_CTRL2   = 7'h11;
  localparam logic [6:0] ADDR_PRESS_X = 7'h28;
  localparam logic [6:0] ADDR_PRESS_L = 7'h29;
  localparam logic [6:0] ADDR_PRESS_H = 7'h2A;
  localparam logic [6:0] ADDR_TEMP_L  = 7'h2B;
  localparam logic [6:0] ADDR_TEMP_H  = 7'h2C;

  // interface_control fields
  localparam int unsigned IF_IRQ_OUT_BIT  = 7;
  localparam int unsigned IF_DATA_PU_BIT  = 6;
  localparam int unsigned IF_SOUT_PU_BIT  = 5;
  localparam int unsigned IF_IRQ_PD_BIT   = 4;
  localparam int unsigned IF_I3C_DIS_BIT  = 3;
  localparam int unsigned IF_I2C_DIS_BIT  = 2;
  localparam logic [7:0]  IF_CTRL_MASK    = 8'hFC;
  localparam logic [7:0]  IF_CTRL_RESET   = 8'h00;

  // acquisition_control_one fields
  localparam int unsigned C1_RATE_LSB     = 4;
  localparam int unsigned C1_FILT_EN_BIT  = 3;
  localparam int unsigned C1_FILT_BW_BIT  = 2;
  localparam int unsigned C1_BLOCK_UPD_BIT = 1;
  localparam int unsigned C1_SPI_WIRE_BIT = 0;
  localparam logic [7:0]  CTRL1_MASK      = 8'h7F;
  localparam logic [7:0]  CTRL1_RESET     = 8'h00;

  // acquisition_control_two fields
  localparam int unsigned C2_BOOT_BIT     = 7;
  localparam int unsigned C2_IRQ_POL_BIT  = 6;
  localparam int unsigned C2_IRQ_DRV_BIT  = 5;
  localparam int unsigned C2_AUTO_INC_BIT = 4;
  localparam int unsigned C2_SOFT_RST_BIT = 2;
  localparam int unsigned C2_LOW_NOISE_BIT = 1;
  localparam int unsigned C2_ONE_SHOT_BIT = 0;
  localparam logic [7:0]  CTRL2_MASK      = 8'hF7;
  localparam logic [7:0]  CTRL2_RESET     = 8'h10;

  // rate codes and output rates
  localparam logic [2:0] RATE_OFF   = 3'h0;
  localparam logic [2:0] RATE_100HZ = 3'h6;
  localparam int unsigned BASE_RATE_HZ = 600;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned BASE_TICK_CYCLES = CLK_HZ / BASE_RATE_HZ;

  // trim copy time after a reload request
  localparam int unsigned BOOT_TIME_NS  = 320;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BOOT_CYCLES   = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] DEVICE_CODE_DEFAULT = 8'h5A;  // arbitrary value

  typedef enum logic [1:0] {
    AIC_BW_HALF      = 2'h1,
    AIC_BW_NINTH     = 2'h2,
    AIC_BW_TWENTIETH = 2'h3
  } aic_bw_t;

  // base ticks per output sample for a rate code
  function automatic logic [9:0] aic_rate_ticks(input logic [2:0] code);
    logic [9:0] t;
    t = 10'(BASE_RATE_HZ);
    case (code)
      3'h1: t = 10'(BASE_RATE_HZ / 1);
      3'h2: t = 10'(BASE_RATE_HZ / 10);
      3'h3: t = 10'(BASE_RATE_HZ / 25);
      3'h4: t = 10'(BASE_RATE_HZ / 50);
      3'h5: t = 10'(BASE_RATE_HZ / 75);
      3'h6: t = 10'(BASE_RATE_HZ / 100);
      3'h7: t = 10'(BASE_RATE_HZ / 200);
      default: t = 10'(BASE_RATE_HZ);
    endcase
    return t;
  endfunction
endpackage

// file: design/aic_if.sv
// register access link between the host controller and the sensor control logic
`timescale 1ns/100ps
`default_nettype none
interface aic_if;
  logic       req;
  logic       start;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport sensor (input req, input start, input we, input addr, input wdata,
                  output ack, output rdata);
  modport host   (output req, output start, output we, output addr, output wdata,
                  input ack, input rdata);
endinterface
`default_nettype wire

// file: design/aic_sensor_end.sv
// sensor-side acquisition and interface control registers
`timescale 1ns/100ps
`default_nettype none
module aic_sensor_end #(
  parameter int unsigned BASE_TICK_CYCLES = aic_pkg::BASE_TICK_CYCLES,
  parameter logic [7:0]  DEVICE_CODE      = aic_pkg::DEVICE_CODE_DEFAULT  // arbitrary value
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  aic_if.sensor                bus,
  output logic                 conv_start,
  input  wire logic            conv_done,
  input  wire logic [23:0]     conv_pressure,
  input  wire logic [15:0]     conv_temp,
  output logic [23:0]          pressure_out,
  output logic [15:0]          temp_out,
  output logic                 sample_update,
  output logic                 low_noise_active,
  output logic                 filter_enable,
  output aic_pkg::aic_bw_t     bandwidth,
  output logic                 spi_wire_mode,
  output logic                 trim_load,
  output logic                 boot_busy,
  input  wire logic            irq_level,
  output logic                 first_irq_pad_out,
  output logic                 first_irq_pad_oe_n,
  output logic                 irq_pad_output_mode,
  output logic                 data_line_pullup_enable,
  output logic                 serial_out_pullup_enable,
  output logic                 irq_pad_pulldown_enable,
  output logic                 i3c_enable,
  output logic                 i2c_enable
);
  typedef enum logic [1:0] {
    AIC_ACQ_IDLE = 2'b01,
    AIC_ACQ_CONV = 2'b10
  } aic_acq_t;

  typedef struct packed {
    logic [7:0]  if_ctrl;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [23:0] press;
    logic [15:0] temp;
    logic [6:0]  ptr;
    logic        ack;
    logic [7:0]  rdata;
    aic_acq_t    acq;
    logic        conv_start;
    logic        sample_update;
    logic        set_lock;
    logic [23:0] base_cnt;
    logic [9:0]  tick_cnt;
    logic        due;
    logic [4:0]  boot_cnt;
    logic        trim_load;
  } aic_dev_state_t;

  aic_dev_state_t s;
  aic_dev_state_t next_s;

  logic [2:0] rate;
  logic [6:0] acc_addr;
  logic       do_soft_rst;

  assign rate     = s.ctrl1[aic_pkg::C1_RATE_LSB +: 3];
  assign acc_addr = bus.start ? bus.addr : s.ptr;

  function automatic logic [7:0] read_reg(input aic_dev_state_t cur, input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      aic_pkg::ADDR_IF_CTRL: d = cur.if_ctrl;
      aic_pkg::ADDR_IDENT:   d = DEVICE_CODE;
      aic_pkg::ADDR_CTRL1:   d = cur.ctrl1;
      aic_pkg::ADDR_CTRL2:   d = cur.ctrl2;
      aic_pkg::ADDR_PRESS_X: d = cur.press[7:0];
      aic_pkg::ADDR_PRESS_L: d = cur.press[15:8];
      aic_pkg::ADDR_PRESS_H: d = cur.press[23:16];
      aic_pkg::ADDR_TEMP_L:  d = cur.temp[7:0];
      aic_pkg::ADDR_TEMP_H:  d = cur.temp[15:8];
      default:               d = 8'h00;
    endcase
    return d;
  endfunction

  always_comb begin
    next_s               = s;
    next_s.ack           = 1'b0;
    next_s.conv_start    = 1'b0;
    next_s.sample_update = 1'b0;
    next_s.trim_load     = 1'b0;
    do_soft_rst          = 1'b0;

    // output rate timebase, idle while powered down
    if (rate == aic_pkg::RATE_OFF) begin
      next_s.base_cnt = 24'h000000;
      next_s.tick_cnt = 10'h000;
      next_s.due      = 1'b0;
    end else if (s.base_cnt >= 24'(BASE_TICK_CYCLES - 1)) begin
      next_s.base_cnt = 24'h000000;
      if (s.tick_cnt >= aic_pkg::aic_rate_ticks(rate) - 10'h001) begin
        next_s.tick_cnt = 10'h000;
        next_s.due      = 1'b1;
      end else begin
        next_s.tick_cnt = s.tick_cnt + 10'h001;
      end
    end else begin
      next_s.base_cnt = s.base_cnt + 24'h000001;
    end

    // register access; the link answers in every mode
    if (bus.req && !s.ack) begin
      next_s.ack   = 1'b1;
      next_s.rdata = read_reg(s, acc_addr);
      next_s.ptr   = s.ctrl2[aic_pkg::C2_AUTO_INC_BIT] ? acc_addr + 7'h01 : acc_addr;
      if (!bus.we) begin
        if (s.ctrl1[aic_pkg::C1_BLOCK_UPD_BIT] &&
            (acc_addr == aic_pkg::ADDR_PRESS_X || acc_addr == aic_pkg::ADDR_PRESS_L)) begin
          next_s.set_lock = 1'b1;
        end
        if (acc_addr == aic_pkg::ADDR_PRESS_H) begin
          next_s.set_lock = 1'b0;
        end
      end else begin
        unique case (acc_addr)
          aic_pkg::ADDR_IF_CTRL: next_s.if_ctrl = bus.wdata & aic_pkg::IF_CTRL_MASK;
          aic_pkg::ADDR_CTRL1:   next_s.ctrl1 = bus.wdata & aic_pkg::CTRL1_MASK;
          aic_pkg::ADDR_CTRL2: begin
            next_s.ctrl2 = bus.wdata & aic_pkg::CTRL2_MASK;
            next_s.ctrl2[aic_pkg::C2_SOFT_RST_BIT] = 1'b0;
            // one-shot is honoured only from power-down with nothing running
            next_s.ctrl2[aic_pkg::C2_ONE_SHOT_BIT] = s.ctrl2[aic_pkg::C2_ONE_SHOT_BIT] ||
              (bus.wdata[aic_pkg::C2_ONE_SHOT_BIT] && rate == aic_pkg::RATE_OFF &&
               s.acq == AIC_ACQ_IDLE);
            next_s.ctrl2[aic_pkg::C2_BOOT_BIT] = s.ctrl2[aic_pkg::C2_BOOT_BIT];
            if (bus.wdata[aic_pkg::C2_BOOT_BIT] && s.boot_cnt == 5'h00) begin
              next_s.ctrl2[aic_pkg::C2_BOOT_BIT] = 1'b1;
              next_s.boot_cnt  = 5'(aic_pkg::BOOT_CYCLES);
              next_s.trim_load = 1'b1;
            end
            do_soft_rst = bus.wdata[aic_pkg::C2_SOFT_RST_BIT];
          end
          default: ;  // identity and unmapped addresses drop writes
        endcase
      end
    end

    // trim copy runs its fixed time, then the bit drops
    if (s.boot_cnt != 5'h00) begin
      next_s.boot_cnt = s.boot_cnt - 5'h01;
      if (s.boot_cnt == 5'h01) begin
        next_s.ctrl2[aic_pkg::C2_BOOT_BIT] = 1'b0;
      end
    end

    unique case (s.acq)
      AIC_ACQ_IDLE: begin
        if (s.ctrl2[aic_pkg::C2_ONE_SHOT_BIT]) begin
          next_s.acq        = AIC_ACQ_CONV;
          next_s.conv_start = 1'b1;
        end else if (s.due && rate != aic_pkg::RATE_OFF) begin
          next_s.acq        = AIC_ACQ_CONV;
          next_s.conv_start = 1'b1;
          next_s.due        = 1'b0;
        end
      end
      AIC_ACQ_CONV: begin
        // a tick that lands mid-conversion is skipped, not queued
        next_s.due = 1'b0;
        if (conv_done) begin
          next_s.acq = AIC_ACQ_IDLE;
          next_s.ctrl2[aic_pkg::C2_ONE_SHOT_BIT] = 1'b0;
          // a sample meeting a locked set is dropped so bytes never mix
          if (!(s.ctrl1[aic_pkg::C1_BLOCK_UPD_BIT] && next_s.set_lock)) begin
            next_s.press         = conv_pressure;
            next_s.temp          = conv_temp;
            next_s.sample_update = 1'b1;
          end
        end
      end
    endcase

    if (do_soft_rst) begin
      next_s.if_ctrl    = aic_pkg::IF_CTRL_RESET;
      next_s.ctrl1      = aic_pkg::CTRL1_RESET;
      next_s.ctrl2      = aic_pkg::CTRL2_RESET;
      next_s.press      = 24'h000000;
      next_s.temp       = 16'h0000;
      next_s.acq        = AIC_ACQ_IDLE;
      next_s.conv_start = 1'b0;
      next_s.set_lock   = 1'b0;
      next_s.base_cnt   = 24'h000000;
      next_s.tick_cnt   = 10'h000;
      next_s.due        = 1'b0;
      next_s.boot_cnt   = 5'h00;
      next_s.trim_load  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s               <= '0;
      s.if_ctrl       <= aic_pkg::IF_CTRL_RESET;
      s.ctrl1         <= aic_pkg::CTRL1_RESET;
      s.ctrl2         <= aic_pkg::CTRL2_RESET;
      s.acq           <= AIC_ACQ_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign bus.ack       = s.ack;
  assign bus.rdata     = s.rdata;
  assign conv_start    = s.conv_start;
  assign pressure_out  = s.press;
  assign temp_out      = s.temp;
  assign sample_update = s.sample_update;
  assign trim_load     = s.trim_load;
  assign boot_busy     = s.ctrl2[aic_pkg::C2_BOOT_BIT];

  assign low_noise_active = s.ctrl2[aic_pkg::C2_LOW_NOISE_BIT] &&
                            rate < aic_pkg::RATE_100HZ;
  assign filter_enable    = s.ctrl1[aic_pkg::C1_FILT_EN_BIT];
  assign bandwidth = !s.ctrl1[aic_pkg::C1_FILT_EN_BIT] ? aic_pkg::AIC_BW_HALF :
                     (s.ctrl1[aic_pkg::C1_FILT_BW_BIT] ? aic_pkg::AIC_BW_TWENTIETH
                                                        : aic_pkg::AIC_BW_NINTH);
  assign spi_wire_mode    = s.ctrl1[aic_pkg::C1_SPI_WIRE_BIT];

  // open-drain only pulls low, so the high pad level is the released one
  logic pad_level;
  assign pad_level = irq_level ^ s.ctrl2[aic_pkg::C2_IRQ_POL_BIT];
  assign first_irq_pad_out  = s.ctrl2[aic_pkg::C2_IRQ_DRV_BIT] ? 1'b0 : pad_level;
  assign first_irq_pad_oe_n = s.ctrl2[aic_pkg::C2_IRQ_DRV_BIT] ? pad_level : 1'b0;

  assign irq_pad_output_mode      = s.if_ctrl[aic_pkg::IF_IRQ_OUT_BIT];
  assign data_line_pullup_enable  = s.if_ctrl[aic_pkg::IF_DATA_PU_BIT];
  assign serial_out_pullup_enable = s.if_ctrl[aic_pkg::IF_SOUT_PU_BIT];
  assign irq_pad_pulldown_enable  = !s.if_ctrl[aic_pkg::IF_IRQ_PD_BIT];
  assign i3c_enable               = !s.if_ctrl[aic_pkg::IF_I3C_DIS_BIT];
  assign i2c_enable               = !s.if_ctrl[aic_pkg::IF_I2C_DIS_BIT];
endmodule
`default_nettype wire

// file: design/aic_host_end.sv
// host controller end: runs register read bursts and single writes, and guards the sensor's host-side usage rules
`timescale 1ns/100ps
`default_nettype none
module aic_host_end (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  aic_if.host             bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [3:0] cmd_count,
  output logic            cmd_refused,
  output logic            cmd_done,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  typedef enum logic [1:0] {
    AIC_H_IDLE = 2'b01,
    AIC_H_XFER = 2'b10
  } aic_hst_t;

  typedef struct packed {
    aic_hst_t   state;
    logic [6:0] addr;
    logic [3:0] left;
    logic       write;
    logic [7:0] wdata;
    logic       first;
    logic [2:0] rate_shadow;
    logic       ln_shadow;
    logic       refused;
    logic       done;
    logic       rd_valid;
    logic [7:0] rd_data;
  } aic_host_state_t;

  aic_host_state_t s;
  aic_host_state_t next_s;

  logic [3:0] len;
  logic [7:0] last_addr;
  logic       bad;

  assign len       = (cmd_count == 4'h0) ? 4'h1 : cmd_count;
  assign last_addr = {1'b0, cmd_addr} + {4'h0, len} - 8'h01;

  always_comb begin
    bad = 1'b0;
    if (cmd_write && cmd_addr == aic_pkg::ADDR_CTRL2 && s.rate_shadow != aic_pkg::RATE_OFF) begin
      bad = cmd_wdata[aic_pkg::C2_ONE_SHOT_BIT] ||
            (cmd_wdata[aic_pkg::C2_LOW_NOISE_BIT] != s.ln_shadow);
    end
    // a burst that spans the pressure high byte must stop on it
    if (!cmd_write && {1'b0, cmd_addr} <= {1'b0, aic_pkg::ADDR_PRESS_H} &&
        last_addr > {1'b0, aic_pkg::ADDR_PRESS_H}) begin
      bad = 1'b1;
    end
  end

  always_comb begin
    next_s          = s;
    next_s.refused  = 1'b0;
    next_s.done     = 1'b0;
    next_s.rd_valid = 1'b0;
    unique case (s.state)
      AIC_H_IDLE: begin
        if (cmd_valid && bad) begin
          next_s.refused = 1'b1;
        end else if (cmd_valid) begin
          next_s.state = AIC_H_XFER;
          next_s.addr  = cmd_addr;
          next_s.left  = cmd_write ? 4'h1 : len;
          next_s.write = cmd_write;
          next_s.wdata = cmd_wdata;
          next_s.first = 1'b1;
          if (cmd_write && cmd_addr == aic_pkg::ADDR_CTRL1) begin
            next_s.rate_shadow = cmd_wdata[aic_pkg::C1_RATE_LSB +: 3];
          end
          if (cmd_write && cmd_addr == aic_pkg::ADDR_CTRL2) begin
            next_s.ln_shadow = cmd_wdata[aic_pkg::C2_LOW_NOISE_BIT];
            if (cmd_wdata[aic_pkg::C2_SOFT_RST_BIT]) begin
              next_s.rate_shadow = aic_pkg::RATE_OFF;
              next_s.ln_shadow   = 1'b0;
            end
          end
        end
      end
      AIC_H_XFER: begin
        if (bus.ack) begin
          next_s.first = 1'b0;
          next_s.left  = s.left - 4'h1;
          if (!s.write) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data  = bus.rdata;
          end
          if (s.left == 4'h1) begin
            next_s.state = AIC_H_IDLE;
            next_s.done  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s       <= '0;
      s.state <= AIC_H_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign bus.req     = (s.state == AIC_H_XFER);
  assign bus.start   = s.first;
  assign bus.we      = s.write;
  assign bus.addr    = s.addr;
  assign bus.wdata   = s.wdata;
  assign cmd_ready   = (s.state == AIC_H_IDLE);
  assign cmd_refused = s.refused;
  assign cmd_done    = s.done;
  assign rd_valid    = s.rd_valid;
  assign rd_data     = s.rd_data;
endmodule
`default_nettype wire

// file: testbench/aic_link_props.sv
// protocol and register checks on the control link between both ends
`timescale 1ns/100ps
`default_nettype none
module aic_link_props #(
  parameter logic [7:0] DEVICE_CODE = aic_pkg::DEVICE_CODE_DEFAULT
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       req,
  input wire logic       start,
  input wire logic       we,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  logic       tk;
  logic       wr_hit;
  logic       c2_hit;
  logic       ln;
  logic [7:0] sh1;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign tk = req && !ack;
  assign wr_hit = tk && we && start;
  assign c2_hit = wr_hit && addr == aic_pkg::ADDR_CTRL2;

  // shadows of what the host has written; a soft reset write clears control one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh1 <= aic_pkg::CTRL1_RESET;
      ln <= 1'b0;
    end else if (wr_hit && addr == aic_pkg::ADDR_CTRL1) begin
      sh1 <= wdata & aic_pkg::CTRL1_MASK;
    end else if (c2_hit) begin
      ln <= wdata[aic_pkg::C2_LOW_NOISE_BIT];
      if (wdata[aic_pkg::C2_SOFT_RST_BIT]) begin
        sh1 <= aic_pkg::CTRL1_RESET;
      end
    end
  end

  ack_answer_a: assert property (tk |=> ack)
    else $error("no ack one cycle after a taken request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(tk))
    else $error("ack without a taken request");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read data changed outside an ack");
  ident_value_a: assert property (
    ack && $past(tk && !we && start && addr == aic_pkg::ADDR_IDENT) |-> rdata == DEVICE_CODE)
    else $error("identity read returned a wrong code");
  ctrl1_kept_a: assert property (
    ack && $past(tk && !we && start && addr == aic_pkg::ADDR_CTRL1) |-> rdata == sh1)
    else $error("control one lost its written value");
  oneshot_idle_a: assert property (
    c2_hit && wdata[aic_pkg::C2_ONE_SHOT_BIT] |-> sh1[6:4] == aic_pkg::RATE_OFF)
    else $error("single shot requested outside power-down");
  quiet_change_a: assert property (
    c2_hit && wdata[aic_pkg::C2_LOW_NOISE_BIT] != ln |-> sh1[6:4] == aic_pkg::RATE_OFF)
    else $error("low-noise bit changed outside power-down");

  cover property (wr_hit);
  cover property (tk && !start);
  cover property (ack && !we);
  cover property (c2_hit && wdata[aic_pkg::C2_ONE_SHOT_BIT]);
endmodule
`default_nettype wire

// file: testbench/test_acquisition_and_interface_control.sv
// bench: host end drives the sensor end over the link, converter stood in by the bench
`timescale 1ns/100ps
`default_nettype none
module test_acquisition_and_interface_control;
  localparam int TICK = 4;
  localparam logic [7:0] CODE = 8'hC3;  // arbitrary value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [3:0] cmd_count = 4'h1;
  logic conv_done = 1'b0;
  logic [23:0] conv_pressure = 24'h000000;
  logic [15:0] conv_temp = 16'h0000;
  logic irq_level = 1'b0;
  logic cmd_ready, cmd_refused, cmd_done, rd_valid, conv_start, sample_update;
  logic low_noise_active, filter_enable, spi_wire_mode, trim_load, boot_busy;
  logic first_irq_pad_out, first_irq_pad_oe_n, irq_pad_output_mode;
  logic data_line_pullup_enable, serial_out_pullup_enable, irq_pad_pulldown_enable;
  logic i3c_enable, i2c_enable, rf;
  logic [7:0] rd_data;
  logic [7:0] rq[$];
  logic [15:0] temp_out;
  logic [15:0] tv = 16'h5E6F;
  logic [23:0] pressure_out, pe, held;
  logic [23:0] pv = 24'hA1B2C3;
  aic_pkg::aic_bw_t bandwidth;
  int fail_count = 0;
  int cmp_count = 0;
  int nst = 0;
  int ntrim = 0;
  int cnt = 0;
  int i, k, n, ns;
  int hz[7] = '{1, 10, 25, 50, 75, 100, 200};

  aic_if link ();
  aic_host_end u_aic_host_end (.bus(link), .*);
  aic_sensor_end #(.BASE_TICK_CYCLES(TICK), .DEVICE_CODE(CODE)) u_aic_sensor_end (.bus(link), .*);
  aic_link_props #(.DEVICE_CODE(CODE)) u_aic_link_props (.ref_clk, .rst, .req(link.req),
    .start(link.start), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata));

  always #10 ref_clk = ~ref_clk;

  // converter stand-in: answers five cycles after a start, lines churn otherwise
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    conv_pressure <= ~conv_pressure;
    conv_temp <= ~conv_temp;
    if (trim_load === 1'b1) ntrim <= ntrim + 1;
    if (conv_start === 1'b1) begin
      nst <= nst + 1;
      cnt <= 5;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        conv_done <= 1'b1;
        conv_pressure <= pv;
        conv_temp <= tv;
        pv <= pv + 24'h010101;
      end
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d,
                     input logic [3:0] c);
    int j;
    rq = {};
    rf = 1'b0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_count <= c;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (j = 0; j < 60; j++) begin
      @(negedge ref_clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (cmd_refused === 1'b1) rf = 1'b1;
      if (cmd_done === 1'b1 || rf) break;
    end
    if (j == 60) chk("cmd_end", 0, 1);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cmd(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [6:0] a, input logic [3:0] c);
    cmd(1'b0, a, 8'h00, c);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    rd(a, 4'h1);
    chk("reg", rq[0], e);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // cycles between the second and third start after a rate change
  task automatic gap(output int g);
    int m;
    for (m = 0; m < 3; m++) begin
      g = 0;
      do begin
        @(negedge ref_clk);
        g++;
      end while (conv_start !== 1'b1 && g < 9000);
    end
  endtask

  task automatic dflt();
    rd(aic_pkg::ADDR_IF_CTRL, 4'h4);
    chk("dflt", {rq[0], rq[1], rq[2], rq[3]}, {8'h00, CODE, 8'h00, 8'h10});
  endtask

  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    dflt();
    chk("pins", {i3c_enable, i2c_enable, irq_pad_pulldown_enable, irq_pad_output_mode,
      data_line_pullup_enable, serial_out_pullup_enable, spi_wire_mode, filter_enable},
      8'hE0);
    wr(aic_pkg::ADDR_IDENT, 8'hFF);
    rdc(aic_pkg::ADDR_IDENT, CODE);
    rdc(7'h20, 8'h00);
    for (i = 2; i < 8; i++) begin
      wr(aic_pkg::ADDR_IF_CTRL, 8'(1 << i));
      chk("pads", {irq_pad_output_mode, data_line_pullup_enable, serial_out_pullup_enable,
        !irq_pad_pulldown_enable, !i3c_enable, !i2c_enable}, 1 << (i - 2));
      rdc(aic_pkg::ADDR_IF_CTRL, 8'(1 << i));
    end
    wr(aic_pkg::ADDR_IF_CTRL, 8'hFF);
    rdc(aic_pkg::ADDR_IF_CTRL, 8'hFC);
    for (i = 0; i < 4; i++) begin
      wr(aic_pkg::ADDR_CTRL1, 8'(i * 4 + i % 2));
      rdc(aic_pkg::ADDR_CTRL1, 8'(i * 4 + i % 2));
      chk("filt", {filter_enable, spi_wire_mode}, i[1:0]);
      chk("bw", bandwidth, i < 2 ? aic_pkg::AIC_BW_HALF : (i == 2 ? aic_pkg::AIC_BW_NINTH
        : aic_pkg::AIC_BW_TWENTIETH));
    end
    wr(aic_pkg::ADDR_CTRL1, 8'h00);
    pe = pv;
    wr(aic_pkg::ADDR_CTRL2, 8'h11);
    for (k = 0; k < 50 && sample_update !== 1'b1; k++) @(negedge ref_clk);
    chk("upd", k < 50, 1);
    chk("p_out", pressure_out, pe);
    chk("t_out", temp_out, tv);
    rd(aic_pkg::ADDR_PRESS_X, 4'h3);
    chk("p_rd", {rq[2], rq[1], rq[0]}, pe);
    rdc(aic_pkg::ADDR_CTRL2, 8'h10);
    ns = nst;
    cyc(60);
    chk("idle", nst - ns, 0);
    for (i = 0; i < 8; i++) begin
      wr(aic_pkg::ADDR_CTRL2, 8'h10 | 8'(i[1:0]) << 5);
      @(posedge ref_clk) irq_level <= i[2];
      @(negedge ref_clk);
      chk("pad", {first_irq_pad_out, first_irq_pad_oe_n},
        i[0] ? {1'b0, i[2] ^ i[1]} : {i[2] ^ i[1], 1'b0});
    end
    wr(aic_pkg::ADDR_CTRL2, 8'h12);
    chk("ln", low_noise_active, 1);
    for (i = 1; i < 8; i++) begin
      wr(aic_pkg::ADDR_CTRL1, 8'(i << 4));
      gap(n);
      chk("period", n, aic_pkg::BASE_RATE_HZ / hz[i - 1] * TICK);
      chk("ln", low_noise_active, i < 6);
    end
    wr(aic_pkg::ADDR_CTRL2, 8'h10);
    chk("refuse", rf, 1);
    wr(aic_pkg::ADDR_CTRL2, 8'h13);
    chk("refuse", rf, 1);
    // host cannot keep pace at the top rate, so it turns block update on
    wr(aic_pkg::ADDR_CTRL1, 8'h72);
    rd(aic_pkg::ADDR_PRESS_X, 4'h1);
    held = pressure_out;
    cyc(60);
    chk("locked", pressure_out, held);
    rd(aic_pkg::ADDR_PRESS_L, 4'h2);
    chk("bytes", {rq[1], rq[0]}, held[23:8]);
    cyc(60);
    chk("free", pressure_out !== held, 1);
    wr(aic_pkg::ADDR_CTRL1, 8'h00);
    cyc(20);
    held = pressure_out;
    ns = nst;
    cyc(100);
    chk("frozen", pressure_out, held);
    chk("starts", nst - ns, 0);
    rdc(aic_pkg::ADDR_CTRL2, 8'h12);
    wr(aic_pkg::ADDR_CTRL2, 8'h90);
    rdc(aic_pkg::ADDR_CTRL2, 8'h90);
    chk("boot", boot_busy, 1);
    cyc(20);
    rdc(aic_pkg::ADDR_CTRL2, 8'h10);
    chk("boot", boot_busy, 0);
    chk("trim", ntrim, 1);
    wr(aic_pkg::ADDR_CTRL2, 8'h00);
    rd(aic_pkg::ADDR_IDENT, 4'h2);
    chk("no_inc", {rq[1], rq[0]}, {CODE, CODE});
    wr(aic_pkg::ADDR_IF_CTRL, 8'hFC);
    wr(aic_pkg::ADDR_CTRL1, 8'h0F);
    wr(aic_pkg::ADDR_CTRL2, 8'h04);
    dflt();
    chk("zeroed", pressure_out, 0);
    chk("bw", bandwidth, aic_pkg::AIC_BW_HALF);
    end_sim();
  end
endmodule
`default_nettype wire
